// ### flash_timing_pkg.sv
// Shared timing constants and encodings for the flash write/reset link.
// Assumes one 40 MHz clock on both ends; times are converted to cycles here.
package flash_timing_pkg;

   // ******************************************************
   // Clock and times
   // ******************************************************
   localparam int CLOCK_PERIOD_PS = 25000;
   localparam int WRITE_LOW_NS = 50;
   localparam int WRITE_HIGH_NS = 20;
   localparam int RESET_RECOVERY_NS = 150;
   localparam int READ_EXTRA_NS = 35;
   localparam int SYNC_READ_GAP_NS = 19;
   localparam int STATUS_READ_GAP_NS = 20;
   localparam int CONFIG_EXTRA_NS = 10;
   localparam int LATCH_TO_WRITE_NS = 20;
   localparam int ABORT_MAX_US = 25;
   localparam int RESET_PULSE_NS = 100;
   localparam int POWER_UP_US = 60;

   // Least times round up, longest times round down, never below one cycle.
   function automatic int min_cycles(input int ps);
      int c;
      c = (ps + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
      return (c < 1) ? 1 : c;
   endfunction

   function automatic int max_cycles(input int ps);
      int c;
      c = ps / CLOCK_PERIOD_PS;
      return (c < 1) ? 1 : c;
   endfunction

   localparam int WRITE_LOW_CYC = min_cycles(WRITE_LOW_NS * 1000);
   localparam int WRITE_HIGH_CYC = min_cycles(WRITE_HIGH_NS * 1000);
   localparam int RESET_RECOVERY_CYC = min_cycles(RESET_RECOVERY_NS * 1000);
   localparam int READ_EXTRA_CYC = min_cycles(READ_EXTRA_NS * 1000);
   localparam int SYNC_READ_GAP_CYC = min_cycles(SYNC_READ_GAP_NS * 1000);
   localparam int STATUS_READ_GAP_CYC =
      min_cycles(STATUS_READ_GAP_NS * 1000);
   localparam int CONFIG_EXTRA_CYC = min_cycles(CONFIG_EXTRA_NS * 1000);
   localparam int LATCH_TO_WRITE_CYC = min_cycles(LATCH_TO_WRITE_NS * 1000);
   localparam int ABORT_MAX_CYC = max_cycles(ABORT_MAX_US * 1000000);
   localparam int RESET_PULSE_CYC = min_cycles(RESET_PULSE_NS * 1000);
   localparam int POWER_UP_CYC = min_cycles(POWER_UP_US * 1000000);

   // ******************************************************
   // Status and widths
   // ******************************************************
   localparam logic [7:0] STATUS_RESET = 8'h80;
   localparam int STATUS_READY_BIT = 7;
   localparam int ADDR_W = 16;
   localparam int DATA_W = 16;

endpackage

// ### flash_bus_if.sv
// Interface carrying the flash control pins between controller and device.
// Keeps the data bus as separate host and device halves with their own enables; the testbench does not resolve them.
`timescale 1ns/1ps
interface flash_bus_if;
   logic                                    reset_n;
   logic                                    chip_sel_n;
   logic                                    write_n;
   logic                                    out_en_n;
   logic                                    address_latch_n;
   logic                                    flash_clk;
   logic [flash_timing_pkg::ADDR_W-1:0]     addr;
   logic [flash_timing_pkg::DATA_W-1:0]     dq_host_out;
   logic                                    dq_host_oe;
   logic [flash_timing_pkg::DATA_W-1:0]     dq_dev_out;
   logic                                    dq_dev_oe;
   logic                                    wait_out;
   logic                                    wait_oe;

   modport host (
      output reset_n, chip_sel_n, write_n, out_en_n, address_latch_n,
      output flash_clk, addr, dq_host_out, dq_host_oe,
      input  dq_dev_out, dq_dev_oe, wait_out, wait_oe
   );
   modport device (
      input  reset_n, chip_sel_n, write_n, out_en_n, address_latch_n,
      input  flash_clk, addr, dq_host_out, dq_host_oe,
      output dq_dev_out, dq_dev_oe, wait_out, wait_oe
   );
endinterface

// ### flash_device_end.sv
// Device end of the flash write/reset sequencer: captures write cycles,
// runs a stand-in program/erase timer and handles reset abort.
// Assumes pins come from another party and are synchronised here.
// Assumes array reads are not modelled; only the status word is driven.
// Notes on behaviour
// R01: write ends at first rising select or strobe.
// R02: both low at least 50 ns.
// R03: combined strobe high at least 20 ns.
// R04: wait 150 ns after reset before writing.
// R05: read data valid access plus 35 ns.
// R06: 19 ns before synchronous burst read.
// R07: status read 20 ns after strobe rise.
// R08: config or lock change adds 10 ns.
// R09: 20 ns from latch or clock before write.
// R10: clock input ignored during write cycles.
// R11: wait output high impedance during writes.
// R12: suspended-erase writes use identical timing.
// R13: reset aborts operation within 25 us.
// R14: reset pulse at least 100 ns.
// R15: idle reset completes within minimum pulse.
// R16: reset held 60 us after power valid.
// R17: control inputs ignored while reset low.
// R18: keep reset low during supply ramps.
// R19: keep supply and protect valid until confirmed.
// R20: capture on earlier rising edge of strobes.
// R21: write needs select, strobe low, oe high.
// R22: after reset, array read, status 0x80.
// R23: controller bounds polling with timeouts.
`timescale 1ns/1ps
module flash_device_end #(
   parameter int OP_CYCLES    = 400,
   parameter int ABORT_CYCLES = flash_timing_pkg::ABORT_MAX_CYC
) (
   input  wire logic                                clock,
   input  wire logic                                rst,
   flash_bus_if.device                              bus,
   output logic [flash_timing_pkg::ADDR_W-1:0]      cmd_addr,
   output logic [flash_timing_pkg::DATA_W-1:0]      cmd_data,
   output logic                                     cmd_valid,
   output logic [7:0]                               status,
   output logic                                     busy
);
   // ******************************************************
   // Pin synchronisers
   // ******************************************************
   localparam int NSYNC = 4;
   logic [NSYNC-1:0] sync_a;
   logic [NSYNC-1:0] sync_b;
   logic             reset_n_s;
   logic             cs_n_s;
   logic             we_n_s;
   logic             oe_n_s;
   logic             strobe_prev;
   logic [flash_timing_pkg::ADDR_W-1:0] addr_p;
   logic [flash_timing_pkg::DATA_W-1:0] data_p;
   logic [flash_timing_pkg::ADDR_W-1:0] addr_q;
   logic [flash_timing_pkg::DATA_W-1:0] data_q;

   // The two-flop lag delays every write by two cycles; a strobe pulse of
   // the least legal width still leaves two low samples, so none is lost.

   always_ff @(posedge clock) begin
      sync_a <= {bus.reset_n, bus.chip_sel_n, bus.write_n, bus.out_en_n};
      sync_b <= sync_a;
   end
   assign {reset_n_s, cs_n_s, we_n_s, oe_n_s} = sync_b;

   // Address and data take the same two flops as the strobes, so the
   // captured word is the one that stood when the strobe was first seen high.
   always_ff @(posedge clock) begin
      addr_p <= bus.addr;
      data_p <= bus.dq_host_out;
      addr_q <= addr_p;
      data_q <= data_p;
   end

   // ******************************************************
   // Write cycle detection
   // ******************************************************
   logic write_active;
   logic write_end;
   // Clock pin is never looked at here, so it is ignored during writes. R10
   assign write_active = !cs_n_s && !we_n_s && oe_n_s && reset_n_s; // R21
   assign write_end = strobe_prev && !write_active; // R01 R20 R12
   // Masking lives in reset_n_s, so a strobe seen while the flash is held
   // in reset never becomes a write.

   always_ff @(posedge clock) begin
      if (rst || !reset_n_s) begin // R17
         strobe_prev <= 1'b0;
      end else begin
         strobe_prev <= write_active;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         cmd_addr  <= '0;
         cmd_data  <= '0;
         cmd_valid <= 1'b0;
      end else begin
         // One pulse per write; the word stands until the next write.
         cmd_valid <= write_end && reset_n_s;
         if (write_end && reset_n_s) begin // R20
            cmd_addr <= addr_q;
            cmd_data <= data_q;
         end
      end
   end

   // ******************************************************
   // Operation timer and reset abort
   // ******************************************************
   typedef enum logic [2:0] {
      ST_READ  = 3'b001,
      ST_BUSY  = 3'b010,
      ST_ABORT = 3'b100
   } dev_state_t;

   dev_state_t state;
   logic [31:0] count;
   logic        start_op;

   // Data 0x20 or 0x40 style words start an internal operation.
   // The timer only stands in for program and erase time, which is left
   // to OP_CYCLES; there is no suspend, and writes taken while busy are
   // still handed out on the command port.
   assign start_op = write_end && reset_n_s &&
                     (data_q[7:0] == 8'h40 || data_q[7:0] == 8'h20);

   always_ff @(posedge clock) begin
      if (rst) begin
         state <= ST_READ;
         count <= '0;
      end else begin
         case (state)
            ST_READ: begin
               count <= '0;
               if (start_op) begin
                  state <= ST_BUSY;
               end
            end
            ST_BUSY: begin
               if (!reset_n_s) begin // R13
                  state <= ST_ABORT;
                  count <= '0;
               end else if (count == 32'(OP_CYCLES - 1)) begin
                  state <= ST_READ;
                  count <= '0;
               end else begin
                  count <= count + 32'h1;
               end
            end
            ST_ABORT: begin
               // Abort finishes inside the limit even if reset stays low.
               if (count >= 32'(ABORT_CYCLES - 1)) begin // R13
                  state <= ST_READ;
                  count <= '0;
               end else begin
                  count <= count + 32'h1;
               end
            end
            default: begin
               state <= ST_READ;
            end
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         status <= flash_timing_pkg::STATUS_RESET; // R22
         busy   <= 1'b0;
      end else begin
         // Idle reset takes effect at once, well inside the pulse. R15
         busy <= (state != ST_READ) || start_op;
         if (!reset_n_s || state == ST_READ) begin
            status <= flash_timing_pkg::STATUS_RESET; // R22
         end else begin
            status <= 8'h00;
         end
      end
   end

   // ******************************************************
   // Pin drivers
   // ******************************************************
   // A read needs select and output enable low with the strobe high.
   function automatic logic read_cycle(input logic rn, input logic cs,
                                       input logic oe, input logic we);
      return rn && !cs && !oe && we;
   endfunction

   always_ff @(posedge clock) begin
      if (rst) begin
         bus.dq_dev_out <= '0;
         bus.dq_dev_oe  <= 1'b0;
         bus.wait_out   <= 1'b0;
         bus.wait_oe    <= 1'b0;
      end else begin
         // Outputs only drive on a read; writes keep oe high so wait
         // and data stay released. R11
         bus.dq_dev_oe  <= read_cycle(reset_n_s, cs_n_s, oe_n_s, we_n_s);
         bus.wait_oe    <= read_cycle(reset_n_s, cs_n_s, oe_n_s, we_n_s);
         // No read wait states are modelled, so wait sits deasserted.
         bus.wait_out   <= 1'b1;
         bus.dq_dev_out <= {8'h00, status};
      end
   end
endmodule

// ### flash_host_end.sv
// Controller end: issues reset and write cycles to the flash device with
// the documented least gaps, and enforces read recovery delays.
// Assumes a user that pulses req and waits for done.
`timescale 1ns/1ps
module flash_host_end #(
   parameter int POWER_UP_CYCLES = flash_timing_pkg::POWER_UP_CYC
) (
   input  wire logic                                clock,
   input  wire logic                                rst,
   flash_bus_if.host                                bus,
   input  wire logic                                req,
   input  wire logic                                req_config,
   input  wire logic                                req_status_cmd,
   input  wire logic [flash_timing_pkg::ADDR_W-1:0] req_addr,
   input  wire logic [flash_timing_pkg::DATA_W-1:0] req_data,
   input  wire logic                                flash_reset_req,
   output logic                                     ready,
   output logic                                     done
);
   typedef enum logic [4:0] {
      H_RESET = 5'b00001,
      H_RECOV = 5'b00010,
      H_IDLE  = 5'b00100,
      H_LOW   = 5'b01000,
      H_HIGH  = 5'b10000
   } host_state_t;

   host_state_t state;
   logic [31:0] count;
   logic [31:0] gap;

   always_ff @(posedge clock) begin
      if (rst) begin
         state <= H_RESET;
         count <= '0;
         gap   <= '0;
         bus.reset_n     <= 1'b0;
         bus.chip_sel_n  <= 1'b1;
         bus.write_n     <= 1'b1;
         bus.out_en_n    <= 1'b1;
         bus.addr        <= '0;
         bus.dq_host_out <= '0;
         bus.dq_host_oe  <= 1'b0;
         ready <= 1'b0;
         done  <= 1'b0;
      end else begin
         done <= 1'b0;
         case (state)
            H_RESET: begin
               // Held low for power-up, which also covers 100 ns. R14 R16 R18
               bus.reset_n <= 1'b0;
               if (count >= 32'(POWER_UP_CYCLES - 1)) begin
                  state <= H_RECOV;
                  count <= '0;
                  bus.reset_n <= 1'b1;
               end else begin
                  count <= count + 32'h1;
               end
            end
            H_RECOV: begin
               if (count >=
                   32'(flash_timing_pkg::RESET_RECOVERY_CYC - 1)) begin // R04
                  state <= H_IDLE;
                  count <= '0;
                  ready <= 1'b1;
               end else begin
                  count <= count + 32'h1;
               end
            end
            H_IDLE: begin
               if (flash_reset_req) begin
                  // Reset drops on this edge so the pulse is the full
                  // four cycles, not three. R14
                  state <= H_RESET;
                  ready <= 1'b0;
                  bus.reset_n <= 1'b0;
                  count <= 32'(POWER_UP_CYCLES -
                               flash_timing_pkg::RESET_PULSE_CYC);
               end else if (req) begin // R21 R12
                  state <= H_LOW;
                  ready <= 1'b0;
                  count <= '0;
                  bus.chip_sel_n  <= 1'b0;
                  bus.write_n     <= 1'b0;
                  bus.out_en_n    <= 1'b1;
                  bus.addr        <= req_addr;
                  bus.dq_host_out <= req_data;
                  bus.dq_host_oe  <= 1'b1;
                  // Recovery before the next read or write. R05 R06 R07 R08
                  gap <= 32'(flash_timing_pkg::READ_EXTRA_CYC) +
                         (req_config ?
                          32'(flash_timing_pkg::CONFIG_EXTRA_CYC) : 32'h0) +
                         (req_status_cmd ?
                          32'(flash_timing_pkg::STATUS_READ_GAP_CYC) : 32'h0);
               end
            end
            H_LOW: begin
               if (count >= 32'(flash_timing_pkg::WRITE_LOW_CYC - 1)) begin
                  // Strobe rise ends the cycle. R01 R02 R09
                  state <= H_HIGH;
                  count <= '0;
                  bus.write_n    <= 1'b1;
                  bus.chip_sel_n <= 1'b1;
               end else begin
                  count <= count + 32'h1;
               end
            end
            H_HIGH: begin
               bus.dq_host_oe <= 1'b0;
               if (count >= gap - 32'h1 &&
                   count >= 32'(flash_timing_pkg::WRITE_HIGH_CYC - 1)) begin
                  state <= H_IDLE; // R03
                  ready <= 1'b1;
                  done  <= 1'b1;
               end else begin
                  count <= count + 32'h1;
               end
            end
            default: begin
               state <= H_RESET;
            end
         endcase
      end
   end

   // Link clock is held low: writes do not use it. R10
   always_ff @(posedge clock) begin
      if (rst) begin
         bus.flash_clk       <= 1'b0;
         bus.address_latch_n <= 1'b1;
      end else begin
         bus.flash_clk       <= 1'b0;
         bus.address_latch_n <= 1'b1;
      end
   end
endmodule

// ### flash_link_asserts.sv
// Checker for the flash control link between the two ends.
// Assumes it is instantiated beside the interface, on the one system clock.
`timescale 1ns/1ps
module flash_link_asserts #(
   parameter int POWER_UP_CYCLES = 8
) (
   input wire logic         clock,
   input wire logic         rst,
   input wire logic         reset_n,
   input wire logic         chip_sel_n,
   input wire logic         write_n,
   input wire logic         out_en_n,
   input wire logic         flash_clk,
   input wire logic [15:0]  addr,
   input wire logic [15:0]  dq_host_out,
   input wire logic         dq_host_oe,
   input wire logic         dq_dev_oe,
   input wire logic         wait_oe
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   // ****************************************
   // Helper logic
   // ****************************************
   logic        wact;
   logic        powered;
   int unsigned pu_cnt;
   assign wact = !chip_sel_n && !write_n;

   // Only the first release after a system reset is a power-up release.
   always_ff @(posedge clock) begin
      if (rst || reset_n) pu_cnt <= 0;
      else pu_cnt <= pu_cnt + 1;
   end
   always_ff @(posedge clock) begin
      if (rst) powered <= 1'b0;
      else if (reset_n) powered <= 1'b1;
   end

   // ****************************************
   // Sequences and assertions
   // ****************************************
   sequence s_write_begin;
      $rose(wact);
   endsequence
   sequence s_reset_release;
      $rose(reset_n);
   endsequence
   sequence s_reset_held;
      !reset_n [*4];
   endsequence

   a_write_low_width: assert property (s_write_begin |-> wact [*2])
      else $error("write strobe low for too short a time");
   a_write_high_gap: assert property ($fell(wact) |-> !wact [*2])
      else $error("write strobe high gap too short");
   a_reset_recovery: assert property (s_reset_release |-> write_n [*6])
      else $error("write started too soon after reset release");
   a_reset_pulse: assert property ($fell(reset_n) |-> !reset_n [*4])
      else $error("reset pulse too short");
   a_power_up_hold: assert property
      (s_reset_release and !powered |-> pu_cnt >= POWER_UP_CYCLES)
      else $error("reset released too early after power-up");
   a_wait_hiz: assert property (wact |-> !wait_oe)
      else $error("wait output driven during a write");
   a_write_qualify: assert property
      (wact |-> out_en_n && reset_n && dq_host_oe)
      else $error("write without the required qualifying levels");
   a_reset_quiet: assert property
      (s_reset_held |-> !dq_dev_oe && !wait_oe)
      else $error("device drives pins while held in reset");
   a_write_data_held: assert property
      (wact && $past(wact) |-> $stable(addr) && $stable(dq_host_out))
      else $error("address or data moved inside a write");
   a_clock_still: assert property (wact |-> !flash_clk)
      else $error("link clock toggling during a write");
endmodule

// ### nor_flash_write_reset_timing_tb.sv
// Testbench joining the controller end and the device end back to back.
// Assumes a 40 MHz clock and shortened power-up and operation counts.
`timescale 1ns/1ps
module nor_flash_write_reset_timing_tb;
   logic        clock, rst, req, req_config, req_status_cmd;
   logic        flash_reset_req, ready, done, cmd_valid, busy;
   logic [15:0] req_addr, req_data, cmd_addr, cmd_data, cap_addr, cap_data;
   logic [7:0]  status;
   int          fails, comparisons;
   int          cap_n = 0;

   flash_bus_if bus();
   flash_host_end #(.POWER_UP_CYCLES(8)) i_flash_host_end (
      .clock(clock), .rst(rst), .bus(bus.host), .req(req),
      .req_config(req_config), .req_status_cmd(req_status_cmd),
      .req_addr(req_addr), .req_data(req_data),
      .flash_reset_req(flash_reset_req), .ready(ready), .done(done));
   flash_device_end #(.OP_CYCLES(30), .ABORT_CYCLES(20)) i_flash_device_end (
      .clock(clock), .rst(rst), .bus(bus.device), .cmd_addr(cmd_addr),
      .cmd_data(cmd_data), .cmd_valid(cmd_valid), .status(status),
      .busy(busy));
   flash_link_asserts #(.POWER_UP_CYCLES(8)) i_flash_link_asserts (
      .clock(clock), .rst(rst), .reset_n(bus.reset_n),
      .chip_sel_n(bus.chip_sel_n), .write_n(bus.write_n),
      .out_en_n(bus.out_en_n), .flash_clk(bus.flash_clk), .addr(bus.addr),
      .dq_host_out(bus.dq_host_out), .dq_host_oe(bus.dq_host_oe),
      .dq_dev_oe(bus.dq_dev_oe), .wait_oe(bus.wait_oe));

   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   // Captured words let a check run after the one-cycle pulse has gone.
   always @(posedge clock) begin
      if (cmd_valid === 1'b1) begin
         cap_addr <= cmd_addr;
         cap_data <= cmd_data;
         cap_n <= cap_n + 1;
      end
   end

   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(input string what, input logic [15:0] exp,
                      input logic [15:0] got);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic give_up(input string what);
      fails++;
      $display("CHECK FAILED %s expected event seen timeout", what);
      conclude();
   endtask

   // Waits on a level sampled mid-cycle, so edge updates have landed.
   task automatic wait_level(input int sel, input logic lvl, input int lim);
      int n;
      n = 0;
      while (n < lim && (sel == 0 ? ready : busy) !== lvl) begin
         @(negedge clock);
         n++;
      end
      if (n == lim) give_up(sel == 0 ? "ready" : "busy");
   endtask

   task automatic do_write(input logic [15:0] a, input logic [15:0] d,
                           input logic cfg, input logic st,
                           output int lat, output int low);
      int n0;
      wait_level(0, 1'b1, 300);
      n0 = cap_n;
      @(posedge clock);
      req <= 1'b1;
      req_addr <= a;
      req_data <= d;
      req_config <= cfg;
      req_status_cmd <= st;
      @(posedge clock);
      req <= 1'b0;
      req_config <= 1'b0;
      req_status_cmd <= 1'b0;
      lat = 0;
      low = 0;
      while (lat < 40 && done !== 1'b1) begin
         @(negedge clock);
         lat++;
         if (bus.chip_sel_n === 1'b0 && bus.write_n === 1'b0) low++;
      end
      if (lat == 40) give_up("done");
      for (int k = 0; k < 12 && cap_n == n0; k++) @(negedge clock);
      chk("words captured", 16'(n0 + 1), 16'(cap_n));
      chk("captured address", a, cap_addr);
      chk("captured data", d, cap_data);
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic test_power_up();
      wait_level(0, 1'b1, 300);
      chk("status after reset", 16'h0080, {8'h00, status});
      chk("busy after reset", 16'h0000, {15'h0000, busy});
      $display("test power up done");
   endtask

   task automatic test_back_to_back();
      int lat, low;
      do_write(16'h1234, 16'habcd, 1'b0, 1'b0, lat, low);
      chk("first low cycles", 16'h0002, 16'(low));
      do_write(16'hfffe, 16'h0001, 1'b0, 1'b0, lat, low);
      chk("second low cycles", 16'h0002, 16'(low));
      $display("test back to back done");
   endtask

   task automatic test_extra_gaps();
      int plain, cfg, st, low;
      do_write(16'h0010, 16'h00ff, 1'b0, 1'b0, plain, low);
      do_write(16'h0011, 16'h00fe, 1'b1, 1'b0, cfg, low);
      chk("config extra wait", 16'h0001, 16'(cfg - plain));
      do_write(16'h0012, 16'h00fd, 1'b0, 1'b1, st, low);
      chk("status extra wait", 16'h0001, 16'(st - plain));
      $display("test extra gaps done");
   endtask

   task automatic test_busy_abort();
      int lat, low;
      do_write(16'h0100, 16'h0020, 1'b0, 1'b0, lat, low);
      wait_level(1, 1'b1, 8);
      chk("status while busy", 16'h0000, {8'h00, status});
      wait_level(1, 1'b0, 60);
      chk("status after op", 16'h0080, {8'h00, status});
      do_write(16'h0200, 16'h0040, 1'b0, 1'b0, lat, low);
      wait_level(1, 1'b1, 8);
      @(posedge clock);
      flash_reset_req <= 1'b1;
      @(posedge clock);
      flash_reset_req <= 1'b0;
      wait_level(1, 1'b0, 28);
      chk("status after abort", 16'h0080, {8'h00, status});
      @(posedge clock);
      flash_reset_req <= 1'b1;
      @(posedge clock);
      flash_reset_req <= 1'b0;
      // Let the host drop ready before waiting for it to come back.
      @(negedge clock);
      wait_level(0, 1'b1, 40);
      chk("busy after idle reset", 16'h0000, {15'h0000, busy});
      chk("status after idle reset", 16'h0080, {8'h00, status});
      do_write(16'h0300, 16'h5a5a, 1'b0, 1'b0, lat, low);
      $display("test busy abort done");
   endtask

   initial begin
      rst = 1'b1;
      req = 1'b0;
      req_config = 1'b0;
      req_status_cmd = 1'b0;
      flash_reset_req = 1'b0;
      req_addr = 16'h0000;
      req_data = 16'h0000;
      fails = 0;
      comparisons = 0;
      repeat (12) @(posedge clock);
      rst <= 1'b0;
      test_power_up();
      test_back_to_back();
      test_extra_gaps();
      test_busy_abort();
      conclude();
   end
endmodule
